// [logic/bit_matrix_pkg.sv]
// Shared constants, operation codes and carrier structs for the matrix unit
package bit_matrix_pkg;

    localparam int DATA_W    = 16;
    localparam int ADDR_W    = 16;
    localparam int LEN_W     = 8;
    localparam int BIT_IDX_W = 4;
    localparam int POS_W     = LEN_W + BIT_IDX_W;

    localparam logic [POS_W-1:0]     POS_FIRST     = 12'h001;
    localparam logic [POS_W-1:0]     POS_NONE      = 12'h000;
    localparam logic [BIT_IDX_W-1:0] BIT_IDX_ZERO  = 4'h0;
    localparam logic [DATA_W-1:0]    ONE_HOT_LSB   = 16'h0001;
    localparam logic [DATA_W-1:0]    WORD_ZERO     = 16'h0000;
    localparam logic [DATA_W-1:0]    FAULT_RESET   = 16'h0000;
    localparam logic [DATA_W-1:0]    FAULT_RESTART = 16'h0001;
    localparam logic [ADDR_W-1:0]    ADDR_RESET    = 16'h0000;

    typedef enum logic [1:0] {
        OP_COMPARE,
        OP_BIT_SET,
        OP_BIT_CLEAR
    } op_type;

    typedef struct packed {
        op_type              op;
        logic                powerIn;
        logic [LEN_W-1:0]    matrixWordCount;
        logic [ADDR_W-1:0]   inputBase;
        logic [ADDR_W-1:0]   refBase;
        logic [ADDR_W-1:0]   maskBase;
        logic [DATA_W-1:0]   pointer;
    } req_type;

    typedef struct packed {
        logic                rd;
        logic                wr;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
    } mem_type;

endpackage

// [logic/bit_locator.sv]
// Maps a one-based matrix bit position to a word offset and a bit mask
`timescale 1ns/1ps

module bit_locator
    import bit_matrix_pkg::*;
(
    input  wire logic [POS_W-1:0]  pos,        // One-based bit position
    output logic      [LEN_W-1:0]  wordOffset, // Word index from matrix base
    output logic      [DATA_W-1:0] bitMask     // One-hot bit within the word
);

    logic [POS_W-1:0] zeroBased;

    always_comb begin
        zeroBased  = pos - POS_FIRST;
        wordOffset = zeroBased[POS_W-1:BIT_IDX_W];
        bitMask    = ONE_HOT_LSB << zeroBased[BIT_IDX_W-1:0];
    end

endmodule // bit_locator

// [logic/bit_matrix_unit.sv]
// Matrix compare and bit set/clear sense engine on a word-wide data memory
`timescale 1ns/1ps

// Contract
// - Enabled compare tests input bits against reference
// - Masked mismatch ignored, scan continues
// - Unmasked mismatch: record, set mask, output, halt
// - Next enabled compare resumes from fault position
// - Start position is fault register plus one
// - Clean end: output low, fault is length+1
// - Fault at or past length restarts at 1
// - Pointer valid when above zero, within length
// - Enabled set writes one, asserts output
// - Disabled set senses bit, output follows it
// - Invalid set pointer keeps output low
// - Enabled clear writes zero, output low
// - Disabled clear senses bit, output follows it
// - Invalid clear pointer always asserts output
// - Bits numbered upward from lowest address
module bit_matrix_unit
    import bit_matrix_pkg::*;
(
    input  wire logic              clk,            // 50 MHz clock
    input  wire logic              rst,            // Async reset, high
    input  wire logic              start,          // Begin one operation
    input  wire req_type           req,            // Operation and operands
    input  wire logic [DATA_W-1:0] memRdata,       // Read data, next cycle
    input  wire logic              faultLoad,      // Preload fault register
    input  wire logic [DATA_W-1:0] faultLoadValue, // Preload value
    output mem_type                mem_q,          // Memory request
    output logic                   busy_q,         // Operation in progress
    output logic                   done_q,         // Operation finished
    output logic                   powerOut_q,     // Outgoing power flow
    output logic      [DATA_W-1:0] faultReg_q      // Fault position register
);

    typedef enum logic [3:0] {
        IDLE,
        FETCH_A,
        FETCH_B,
        FETCH_M,
        CAP_B,
        CAP_M,
        SCAN,
        PT_RD,
        PT_WAIT,
        PT_CAP,
        FINISH
    } state_type;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    state_type          state_q,    state_d;
    op_type             op_q,       op_d;
    logic               power_q,    power_d;
    logic [POS_W-1:0]   lenBits_q,  lenBits_d;
    logic [POS_W-1:0]   pos_q,      pos_d;
    logic [ADDR_W-1:0]  baseA_q,    baseA_d;
    logic [ADDR_W-1:0]  baseB_q,    baseB_d;
    logic [ADDR_W-1:0]  baseM_q,    baseM_d;
    logic [DATA_W-1:0]  wordA_q,    wordA_d;
    logic [DATA_W-1:0]  wordB_q,    wordB_d;
    logic [DATA_W-1:0]  wordM_q,    wordM_d;
    logic [DATA_W-1:0]  faultReg_d;
    mem_type            mem_d;
    logic               busy_d;
    logic               done_d;
    logic               powerOut_d;

    logic [LEN_W-1:0]   wordOffset;
    logic [DATA_W-1:0]  bitMask;
    logic [POS_W-1:0]   reqLenBits;
    logic               ptrValid;
    logic               miss;
    logic               masked;
    logic               bitOn;

    bit_locator locator (
        .pos        (pos_q),
        .wordOffset (wordOffset),
        .bitMask    (bitMask)
    );

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        state_d    = state_q;
        op_d       = op_q;
        power_d    = power_q;
        lenBits_d  = lenBits_q;
        pos_d      = pos_q;
        baseA_d    = baseA_q;
        baseB_d    = baseB_q;
        baseM_d    = baseM_q;
        wordA_d    = wordA_q;
        wordB_d    = wordB_q;
        wordM_d    = wordM_q;
        faultReg_d = faultReg_q;
        busy_d     = busy_q;
        done_d     = 1'h0;
        powerOut_d = powerOut_q;
        mem_d      = mem_q;
        mem_d.rd   = 1'h0;
        mem_d.wr   = 1'h0;

        reqLenBits = {req.matrixWordCount, BIT_IDX_ZERO};
        ptrValid   = (req.pointer != WORD_ZERO) &&
                     (req.pointer <= DATA_W'(reqLenBits));
        miss       = |((wordA_q ^ wordB_q) & bitMask);
        masked     = |(wordM_q & bitMask);
        bitOn      = |(memRdata & bitMask);

        case (state_q)
            IDLE: begin
                if (faultLoad) begin
                    faultReg_d = faultLoadValue;
                end
                if (start) begin
                    op_d       = req.op;
                    power_d    = req.powerIn;
                    lenBits_d  = reqLenBits;
                    baseA_d    = req.inputBase;
                    baseB_d    = req.refBase;
                    baseM_d    = req.maskBase;
                    powerOut_d = 1'h0;
                    if (req.op == OP_COMPARE) begin
                        if (!req.powerIn || reqLenBits == POS_NONE) begin
                            done_d = 1'h1;
                        end else begin
                            busy_d  = 1'h1;
                            state_d = FETCH_A;
                            if (faultReg_d >= DATA_W'(reqLenBits)) begin
                                pos_d = POS_FIRST;
                            end else begin
                                pos_d = faultReg_d[POS_W-1:0]
                                      + POS_FIRST;
                            end
                        end
                    end else if (ptrValid) begin
                        busy_d  = 1'h1;
                        pos_d   = req.pointer[POS_W-1:0];
                        state_d = PT_RD;
                    end else begin
                        done_d     = 1'h1;
                        powerOut_d = (req.op == OP_BIT_CLEAR);
                    end
                end
            end
            FETCH_A: begin
                mem_d.rd   = 1'h1;
                mem_d.addr = baseA_q + ADDR_W'(wordOffset);
                state_d    = FETCH_B;
            end
            FETCH_B: begin
                mem_d.rd   = 1'h1;
                mem_d.addr = baseB_q + ADDR_W'(wordOffset);
                state_d    = FETCH_M;
            end
            FETCH_M: begin
                mem_d.rd   = 1'h1;
                mem_d.addr = baseM_q + ADDR_W'(wordOffset);
                wordA_d    = memRdata;
                state_d    = CAP_B;
            end
            CAP_B: begin
                wordB_d = memRdata;
                state_d = CAP_M;
            end
            CAP_M: begin
                wordM_d = memRdata;
                state_d = SCAN;
            end
            SCAN: begin
                if (miss && !masked) begin
                    faultReg_d  = DATA_W'(pos_q);
                    mem_d.wr    = 1'h1;
                    mem_d.addr  = baseM_q + ADDR_W'(wordOffset);
                    mem_d.wdata = wordM_q | bitMask;
                    powerOut_d  = 1'h1;
                    state_d     = FINISH;
                end else if (pos_q == lenBits_q) begin
                    faultReg_d = DATA_W'(pos_q + POS_FIRST);
                    state_d    = FINISH;
                end else begin
                    pos_d = pos_q + POS_FIRST;
                    if (bitMask[DATA_W-1]) begin
                        state_d = FETCH_A;
                    end
                end
            end
            PT_RD: begin
                mem_d.rd   = 1'h1;
                mem_d.addr = baseA_q + ADDR_W'(wordOffset);
                state_d    = PT_WAIT;
            end
            PT_WAIT: begin
                state_d = PT_CAP;
            end
            PT_CAP: begin
                if (power_q) begin
                    mem_d.wr   = 1'h1;
                    mem_d.addr = baseA_q + ADDR_W'(wordOffset);
                    if (op_q == OP_BIT_SET) begin
                        mem_d.wdata = memRdata | bitMask;
                        powerOut_d  = 1'h1;
                    end else begin
                        mem_d.wdata = memRdata & ~bitMask;
                        powerOut_d  = 1'h0;
                    end
                end else begin
                    powerOut_d = bitOn;
                end
                state_d = FINISH;
            end
            FINISH: begin
                done_d  = 1'h1;
                busy_d  = 1'h0;
                state_d = IDLE;
            end
            default: begin
                state_d = IDLE;
                busy_d  = 1'h0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q    <= IDLE;
            op_q       <= OP_COMPARE;
            power_q    <= 1'h0;
            lenBits_q  <= POS_NONE;
            pos_q      <= POS_FIRST;
            baseA_q    <= ADDR_RESET;
            baseB_q    <= ADDR_RESET;
            baseM_q    <= ADDR_RESET;
            wordA_q    <= WORD_ZERO;
            wordB_q    <= WORD_ZERO;
            wordM_q    <= WORD_ZERO;
            faultReg_q <= FAULT_RESET;
            busy_q     <= 1'h0;
            done_q     <= 1'h0;
            powerOut_q <= 1'h0;
            mem_q      <= '0;
        end else begin
            state_q    <= state_d;
            op_q       <= op_d;
            power_q    <= power_d;
            lenBits_q  <= lenBits_d;
            pos_q      <= pos_d;
            baseA_q    <= baseA_d;
            baseB_q    <= baseB_d;
            baseM_q    <= baseM_d;
            wordA_q    <= wordA_d;
            wordB_q    <= wordB_d;
            wordM_q    <= wordM_d;
            faultReg_q <= faultReg_d;
            busy_q     <= busy_d;
            done_q     <= done_d;
            powerOut_q <= powerOut_d;
            mem_q      <= mem_d;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    invalid_set_low_a: assert property (
        start && !busy_q && req.op == OP_BIT_SET && !ptrValid
        |=> done_q && !powerOut_q)
        else $error("invalid set pointer gave power");

    invalid_clear_high_a: assert property (
        start && !busy_q && req.op == OP_BIT_CLEAR && !ptrValid
        |=> done_q && powerOut_q)
        else $error("invalid clear pointer gave no power");

    clean_end_fault_a: assert property (
        done_q && op_q == OP_COMPARE && power_q && !powerOut_q
        |-> faultReg_q == DATA_W'(lenBits_q + POS_FIRST))
        else $error("clean compare left wrong fault value");

    fault_in_range_a: assert property (
        done_q && op_q == OP_COMPARE && powerOut_q
        |-> faultReg_q != WORD_ZERO && faultReg_q <= DATA_W'(lenBits_q))
        else $error("fault position out of range");

    mask_write_set_a: assert property (
        state_q == SCAN && miss && !masked
        |=> mem_q.wr && (mem_q.wdata & bitMask) != WORD_ZERO
            ##1 done_q && powerOut_q)
        else $error("mask bit not set on recorded fault");

    clear_write_low_a: assert property (
        state_q == PT_CAP && power_q && op_q == OP_BIT_CLEAR
        |=> mem_q.wr && (mem_q.wdata & bitMask) == WORD_ZERO
            ##1 done_q && !powerOut_q)
        else $error("enabled clear misbehaved");

    sense_no_write_a: assert property (
        mem_q.wr |-> power_q)
        else $error("memory written without enable");

    restart_first_a: assert property (
        state_q == IDLE && start && req.op == OP_COMPARE && req.powerIn
        && req.matrixWordCount != '0 && !faultLoad
        && faultReg_q >= DATA_W'(reqLenBits)
        |=> pos_q == POS_FIRST && state_q == FETCH_A)
        else $error("compare did not restart at first bit");

    // A start taken in the done cycle may legally end at once again
    done_pulse_a: assert property (
        done_q && !start |=> !done_q)
        else $error("done held longer than one cycle");

endmodule // bit_matrix_unit

// [tb/bit_matrix_mem.sv]
// Synchronous one-cycle data memory that faces the matrix unit
`timescale 1ns/1ps

module bit_matrix_mem
    import bit_matrix_pkg::*;
(
    input  wire logic              clk,      // Unit clock
    input  wire mem_type           mem_q,    // Request from the unit
    output logic      [DATA_W-1:0] memRdata  // Read data, cycle after rd
);
    // Word storage, so every matrix starts on a word boundary
    logic [DATA_W-1:0] words [0:255];

    initial begin
        for (int i = 0; i < 256; i++) begin
            words[i] = WORD_ZERO;
        end
    end

    always @(posedge clk) begin
        if (mem_q.wr) begin
            words[mem_q.addr[7:0]] <= mem_q.wdata;
        end
        // Outside a read the data lines invert their last value each cycle
        if (mem_q.rd) begin
            memRdata <= words[mem_q.addr[7:0]];
        end else begin
            memRdata <= ~memRdata;
        end
    end
endmodule // bit_matrix_mem

// [tb/tb_top.sv]
// Self-checking bench for the matrix compare and bit set/clear unit
`timescale 1ns/1ps

module tb_top;
    import bit_matrix_pkg::*;

    logic              clk;
    logic              rst;
    logic              start;
    req_type           req;
    logic [DATA_W-1:0] memRdata;
    logic              faultLoad;
    logic [DATA_W-1:0] faultLoadValue;
    mem_type           mem_q;
    logic              busy_q;
    logic              done_q;
    logic              powerOut_q;
    logic [DATA_W-1:0] faultReg_q;
    int                n_mismatch;
    int                n_compared;

    bit_matrix_unit dut_u (.clk(clk), .rst(rst), .start(start), .req(req),
        .memRdata(memRdata), .faultLoad(faultLoad),
        .faultLoadValue(faultLoadValue), .mem_q(mem_q), .busy_q(busy_q),
        .done_q(done_q), .powerOut_q(powerOut_q), .faultReg_q(faultReg_q));

    bit_matrix_mem mem_u (.clk(clk), .mem_q(mem_q), .memRdata(memRdata));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic stop_test;
        $display("Mismatches %0d, comparisons %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [DATA_W-1:0] got, exp,
                            input string msg);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s got %b exp %b", $time, msg, got, exp);
        end
    endtask

    // One operation: start pulse, then bounded wait for done
    task automatic run_op(input op_type op, input logic pin,
                          input logic [LEN_W-1:0] len,
                          input logic [DATA_W-1:0] ptr);
        int n;
        @(negedge clk);
        req.op = op;
        req.powerIn = pin;
        req.matrixWordCount = len;
        req.pointer = ptr;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        n = 0;
        while (done_q !== 1'b1 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 5000) begin
            n_mismatch++;
            $display("[FAIL] %0t no done", $time);
        end
    endtask

    task automatic preload(input logic [DATA_W-1:0] v);
        @(negedge clk);
        faultLoad = 1'b1;
        faultLoadValue = v;
        @(negedge clk);
        faultLoad = 1'b0;
    endtask

    task automatic set_mats(input logic [DATA_W-1:0] a, b, m);
        mem_u.words[8'h10] = a;
        mem_u.words[8'h20] = b;
        mem_u.words[8'h30] = m;
    endtask

    // Mirrors the four-case table: halt at position 4
    task automatic t_halt;
        set_mats(16'h000e, 16'h0002, 16'h0004);
        preload(16'h0000);
        run_op(OP_COMPARE, 1'b1, 8'h01, 16'h0000);
        chk_word(faultReg_q, 16'h0004, "halt pos");
        chk_bit(powerOut_q, 1'b1, "halt power");
        chk_word(mem_u.words[8'h30], 16'h000c, "mask set");
    endtask

    // Mismatch behind the halt point is skipped until the scan restarts at 1
    task automatic t_resume;
        mem_u.words[8'h20] = 16'h0000;
        run_op(OP_COMPARE, 1'b1, 8'h01, 16'h0000);
        chk_word(faultReg_q, 16'h0011, "end pos");
        chk_bit(powerOut_q, 1'b0, "end power");
        run_op(OP_COMPARE, 1'b1, 8'h01, 16'h0000);
        chk_word(faultReg_q, 16'h0002, "restart pos");
        chk_bit(powerOut_q, 1'b1, "restart power");
    endtask

    // Mismatch in the second word, then a compare without power
    task automatic t_words;
        set_mats(16'h0000, 16'h0000, 16'h0000);
        mem_u.words[8'h11] = 16'h0008;
        mem_u.words[8'h21] = 16'h0000;
        mem_u.words[8'h31] = 16'h0000;
        preload(16'h0000);
        run_op(OP_COMPARE, 1'b1, 8'h02, 16'h0000);
        chk_word(faultReg_q, 16'h0014, "word two pos");
        chk_word(mem_u.words[8'h31], 16'h0008, "mask two");
        run_op(OP_COMPARE, 1'b0, 8'h02, 16'h0000);
        chk_word(faultReg_q, 16'h0014, "no power pos");
        chk_bit(powerOut_q, 1'b0, "no power out");
    endtask

    task automatic do_bit(input op_type op, input logic pin,
                          input logic [DATA_W-1:0] ptr, init,
                          input logic expPow,
                          input logic [DATA_W-1:0] expWord);
        mem_u.words[8'h11] = init;
        run_op(op, pin, 8'h02, ptr);
        chk_bit(powerOut_q, expPow, "bit op power");
        chk_word(mem_u.words[8'h11], expWord, "bit op word");
    endtask

    task automatic t_bits;
        do_bit(OP_BIT_SET, 1'b1, 16'h0011, 16'h0000, 1'b1, 16'h0001);
        do_bit(OP_BIT_SET, 1'b0, 16'h0020, 16'h8000, 1'b1, 16'h8000);
        do_bit(OP_BIT_SET, 1'b0, 16'h0020, 16'h7fff, 1'b0, 16'h7fff);
        do_bit(OP_BIT_SET, 1'b1, 16'h0021, 16'h0000, 1'b0, 16'h0000);
        do_bit(OP_BIT_SET, 1'b1, 16'h0000, 16'h0000, 1'b0, 16'h0000);
        do_bit(OP_BIT_CLEAR, 1'b1, 16'h0014, 16'hffff, 1'b0, 16'hfff7);
        do_bit(OP_BIT_CLEAR, 1'b0, 16'h0014, 16'h0008, 1'b1, 16'h0008);
        do_bit(OP_BIT_CLEAR, 1'b0, 16'h0014, 16'hfff7, 1'b0, 16'hfff7);
        do_bit(OP_BIT_CLEAR, 1'b0, 16'h0021, 16'h0000, 1'b1, 16'h0000);
        do_bit(OP_BIT_CLEAR, 1'b1, 16'h0000, 16'hffff, 1'b1, 16'hffff);
    endtask

    initial begin
        n_mismatch = 0;
        n_compared = 0;
        rst = 1'b1;
        start = 1'b0;
        faultLoad = 1'b0;
        faultLoadValue = 16'h0000;
        req = '0;
        req.inputBase = 16'h0010;
        req.refBase = 16'h0020;
        req.maskBase = 16'h0030;
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        chk_word(faultReg_q, 16'h0000, "reset fault");
        t_halt;
        t_resume;
        t_words;
        t_bits;
        stop_test;
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        $display("[FAIL] %0t watchdog expired", $time);
        stop_test;
    end
endmodule // tb_top
